// [trr_sequencer.sv]
// Function
// - enable bit on/off, field picks bank
// - self-clear after third precharge plus delay
// - disable write ignores bank field
// - three activate/precharge pairs counted
// - precharge-all counts as target precharge
// - last pre; complete after tMRD delay
// - target activates leave refresh counter
// - restore rows degraded by target row
`include "trr_cfg.svh"
module trr_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic targeted_refresh_mode,
  output logic [2:0] target_bank,
  output logic restore_pulse
);
  localparam logic [4:0] MRD_CYC = 5'(`TRR_TMRD_CYC);
  logic [7:0] ctrl_r, ctrl_nxt;
  trr_pkg::trr_state_t st_r, st_nxt;
  logic [1:0] act_r, act_nxt, pre_r, pre_nxt;
  logic [4:0] dly_r, dly_nxt;
  logic [15:0] refcnt_r, refcnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic restore_r, restore_nxt;
  logic wr, rd, ctrl_wr, cmd_wr, bank_hit, is_pre;
  trr_pkg::trr_cmd_t cmd;
  trr_pkg::trr_sel_t sel;

  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign ctrl_wr = wr & (paddr == `TRR_OFS_CTRL);
  assign cmd_wr = wr & (paddr == `TRR_OFS_CMD);
  // command port: [1:0] command, [6:4] bank
  assign cmd = trr_pkg::trr_cmd_t'(pwdata[1:0]);
  assign bank_hit = pwdata[6:4] == ctrl_r[`TRR_BANK_MSB:`TRR_BANK_LSB];
  assign sel = '{en: pwdata[`TRR_EN_BIT], bank: pwdata[`TRR_BANK_MSB:`TRR_BANK_LSB]};
  // precharge-all stands in for the target bank precharge
  assign is_pre = (cmd == trr_pkg::TRR_CMD_PRECHARGE_ALL_BANKS) | ((cmd == trr_pkg::TRR_CMD_PRE) & bank_hit);

  always_comb begin
    ctrl_nxt = ctrl_r;
    st_nxt = st_r;
    act_nxt = act_r;
    pre_nxt = pre_r;
    dly_nxt = dly_r;
    refcnt_nxt = refcnt_r;
    restore_nxt = 1'b0;
    pslverr = 1'b0;
    if (psel & penable) begin
      pslverr = !(paddr == `TRR_OFS_CTRL || paddr == `TRR_OFS_CMD ||
                  paddr == `TRR_OFS_STATUS || paddr == `TRR_OFS_REFCNT);
    end
    if (ctrl_wr) begin
      if (sel.en) begin
        ctrl_nxt = pwdata[7:0];
        st_nxt = trr_pkg::TRR_WAIT_MRD;
        dly_nxt = MRD_CYC;
        act_nxt = 2'h0;
        pre_nxt = 2'h0;
      end else begin
        // bank field ignored on disable
        ctrl_nxt = {1'b0, ctrl_r[6:0]};
        st_nxt = trr_pkg::TRR_IDLE;
      end
    end else begin
      case (st_r)
        trr_pkg::TRR_IDLE: begin
          if (cmd_wr && cmd == trr_pkg::TRR_CMD_REF) begin
            refcnt_nxt = refcnt_r + 16'h0001;
          end
        end
        trr_pkg::TRR_WAIT_MRD: begin
          if (dly_r <= 5'h1) begin
            st_nxt = trr_pkg::TRR_RUN;
          end else begin
            dly_nxt = dly_r - 5'h1;
          end
        end
        trr_pkg::TRR_RUN: begin
          if (cmd_wr) begin
            // target activates give no refresh credit
            if (cmd == trr_pkg::TRR_CMD_ACT && bank_hit && act_r == pre_r) begin
              act_nxt = act_r + 2'h1;
            end else if (is_pre && act_r != pre_r) begin
              pre_nxt = pre_r + 2'h1;
              restore_nxt = 1'b1;
              if (pre_r == 2'h2) begin
                st_nxt = trr_pkg::TRR_DONE_WAIT;
                dly_nxt = MRD_CYC;
              end
            end
          end
        end
        trr_pkg::TRR_DONE_WAIT: begin
          if (dly_r <= 5'h1) begin
            ctrl_nxt = {1'b0, ctrl_r[6:0]};
            st_nxt = trr_pkg::TRR_IDLE;
          end else begin
            dly_nxt = dly_r - 5'h1;
          end
        end
        default: st_nxt = trr_pkg::TRR_IDLE;
      endcase
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TRR_OFS_CTRL: prdata_nxt = {24'h000000, ctrl_r};
        `TRR_OFS_STATUS: prdata_nxt = {24'h000000, st_r, 1'b0, pre_r, act_r};
        `TRR_OFS_REFCNT: prdata_nxt = {16'h0000, refcnt_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TRR_CTRL_RST;
      st_r <= trr_pkg::TRR_IDLE;
      act_r <= 2'h0;
      pre_r <= 2'h0;
      dly_r <= 5'h0;
      refcnt_r <= 16'h0000;
      prdata_r <= 32'h00000000;
      restore_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      st_r <= st_nxt;
      act_r <= act_nxt;
      pre_r <= pre_nxt;
      dly_r <= dly_nxt;
      refcnt_r <= refcnt_nxt;
      prdata_r <= prdata_nxt;
      restore_r <= restore_nxt;
    end
  end

  assign prdata = rd ? prdata_r : 32'h00000000;
  assign targeted_refresh_mode = ctrl_r[`TRR_EN_BIT];
  assign target_bank = ctrl_r[`TRR_BANK_MSB:`TRR_BANK_LSB];
  assign restore_pulse = restore_r;
endmodule

// [trr_cfg.svh]
`ifndef TRR_CFG_SVH
`define TRR_CFG_SVH
`define TRR_OFS_CTRL 12'h000
`define TRR_OFS_CMD 12'h004
`define TRR_OFS_STATUS 12'h008
`define TRR_OFS_REFCNT 12'h00c
`define TRR_EN_BIT 7
`define TRR_BANK_LSB 4
`define TRR_BANK_MSB 6
`define TRR_CTRL_RST 8'h00
`define TRR_TMRD_NS 14
`define TRR_CLK_MHZ 125
`define TRR_TMRD_CYC ((`TRR_TMRD_NS * `TRR_CLK_MHZ + 999) / 1000)
`endif

// [trr_pkg.sv]
package trr_pkg;
  typedef enum logic [2:0] {
    TRR_IDLE = 3'b000,
    TRR_WAIT_MRD = 3'b001,
    TRR_RUN = 3'b011,
    TRR_DONE_WAIT = 3'b010
  } trr_state_t;
  typedef enum logic [1:0] {
    TRR_CMD_ACT = 2'h0,
    TRR_CMD_PRE = 2'h1,
    TRR_CMD_PRECHARGE_ALL_BANKS = 2'h2,
    TRR_CMD_REF = 2'h3
  } trr_cmd_t;
  typedef struct packed {
    logic en;
    logic [2:0] bank;
  } trr_sel_t;
endpackage

// [trr_seq_asserts.sv]
module trr_seq_asserts(
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic targeted_refresh_mode, restore_pulse,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [2:0] target_bank);
  timeunit 1ns;
  timeprecision 1ns;
  logic cw;
  logic md;
  assign cw = psel && penable && pwrite && paddr == 12'h000;
  assign md = targeted_refresh_mode;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mode_set_a: assert property (cw && pwdata[7] |=> md && target_bank == $past(pwdata[6:4]))
    else $error("entry lost");
  mode_clr_a: assert property (cw && !pwdata[7] |=> !md && $stable(target_bank))
    else $error("exit lost");
  mode_rise_a: assert property ($rose(md) |-> $past(cw && pwdata[7]))
    else $error("stray entry");
  bank_hold_a: assert property (!cw |=> $stable(target_bank))
    else $error("bank moved");
  pulse_src_a: assert property (restore_pulse |-> $past(md && psel && penable && paddr == 12'h004
    && pwdata[1:0] inside {2'h1, 2'h2}))
    else $error("stray restore");
  pulse_one_a: assert property (restore_pulse |=> !restore_pulse)
    else $error("long restore");
  mode_fall_a: assert property ($fell(md) |-> $past(cw) || $past(restore_pulse, 2) || $past(restore_pulse, 3))
    else $error("stray exit");
  bad_addr_a: assert property (psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
    else $error("unmapped taken");
  cover property (restore_pulse);
  cover property ($fell(md) && !$past(cw));
  cover property (cw && !pwdata[7] && md);
endmodule
bind trr_sequencer trr_seq_asserts u_trr_seq_asserts(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .targeted_refresh_mode(targeted_refresh_mode), .restore_pulse(restore_pulse), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .target_bank(target_bank));

// [trr_ctl_model.sv]
module trr_ctl_model(
  input wire logic pclk, pready,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    // let the edge's updates settle before callers look at outputs
    #1;
  endtask
endmodule

// [trr_tb.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, targeted_refresh_mode, restore_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] target_bank;
  int num_errors, n_checks, cyc, np, ne;
  always #4 pclk = ~pclk;
  trr_ctl_model u_trr_ctl_model(.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  trr_sequencer u_trr_sequencer(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .targeted_refresh_mode(targeted_refresh_mode), .target_bank(target_bank), .restore_pulse(restore_pulse));
  task automatic chk(input logic [31:0] s, e);
    #1;
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_trr_ctl_model.xf(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_trr_ctl_model.xf(1'b1, a, d, r);
  endtask
  task automatic cm(input logic [1:0] c, input logic [2:0] b);
    wr(12'h004, {25'h0, b, 2'h0, c});
  endtask
  task results;
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    np += int'(restore_pulse === 1'b1);
    ne += int'(pslverr === 1'b1 && psel === 1'b1 && penable === 1'b1);
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    cm(2'h3, 3'h0);
    rd(12'h00c, 32'h1);
    rd(12'h020, 32'h0);
    chk(ne, 1);
    wr(12'h000, 32'ha0);
    chk({targeted_refresh_mode, target_bank}, 4'ha);
    cm(2'h1, 3'h2);
    cm(2'h0, 3'h5);
    for (int i = 0; i < 3; i++) begin
      chk(targeted_refresh_mode, 1'b1);
      cm(2'h0, 3'h2);
      cm(i == 1 ? 2'h2 : 2'h1, 3'h2);
    end
    chk(targeted_refresh_mode, 1'b1);
    @(posedge pclk);
    chk(targeted_refresh_mode, 1'b1);
    @(posedge pclk);
    #1;
    chk(targeted_refresh_mode, 1'b0);
    chk(np, 3);
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h20);
    rd(12'h008, 32'h0f);
    rd(12'h00c, 32'h1);
    wr(12'h000, 32'h90);
    cm(2'h0, 3'h1);
    wr(12'h000, 32'h60);
    chk({targeted_refresh_mode, target_bank}, 4'h1);
    repeat (3) cm(2'h1, 3'h1);
    chk(np, 3);
    chk(ne, 1);
    rd(12'h000, 32'h10);
    results();
  end
endmodule
